// file: src/bcf_pkg.sv
// Constants, carrier types and states for the banked clock fan-out with phase-lock loop
package bcf_pkg;

    // ------------------------------------------------------------
    // Sizes and counts
    // ------------------------------------------------------------
    localparam int BCF_CNT_W_DEF = 16;
    localparam int BCF_LOCK_PERIODS_DEF = 16;
    localparam int BCF_MIN_PERIOD = 4;
    localparam int BCF_MISS_LIMIT = 3;
    localparam int BCF_NUM_BANKS = 4;
    localparam int BCF_BANK_WIDTH = 4;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] BCF_REG_CTRL = 8'h00;
    localparam logic [7:0] BCF_REG_STATUS = 8'h04;
    localparam logic [7:0] BCF_REG_PERIOD = 8'h08;
    localparam logic [7:0] BCF_REG_PHASE = 8'h0C;
    localparam int BCF_CTRL_RELOCK_BIT = 0;
    localparam int BCF_STAT_LOCKED_BIT = 0;
    localparam int BCF_STAT_BYPASS_BIT = 1;
    localparam int BCF_STAT_STATE_LSB = 2;
    localparam int BCF_STAT_EN_LSB = 4;
    localparam int BCF_STAT_REF_OK_BIT = 8;
    localparam logic [31:0] BCF_RDATA_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BCF_LK_WAIT,
        BCF_LK_ACQUIRE,
        BCF_LK_LOCKED
    } bcf_lock_e;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } bcf_wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } bcf_wb_rsp_s;

endpackage : bcf_pkg

// file: src/bcf_edge_meter.sv
// Rising-edge detector and period meter for a sampled clock-like input
`timescale 1ns/1ps
`default_nettype none
module bcf_edge_meter #(
    parameter int CNT_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sig_i,
    output logic rise_o,
    output logic [CNT_W-1:0] period_o,
    output logic stable_o
);
    import bcf_pkg::*;

    initial begin
        if (CNT_W < 4) begin
            $error("bcf_edge_meter: CNT_W must be at least 4");
        end
    end

    localparam logic [CNT_W-1:0] CNT_LIMIT = {1'b0, {(CNT_W-1){1'b1}}};
    localparam logic [CNT_W-1:0] MIN_P = CNT_W'(BCF_MIN_PERIOD);

    typedef struct packed {
        logic prev;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] period;
        logic stable;
    } bcf_meter_s;

    bcf_meter_s q, d;
    logic rise;
    logic [CNT_W-1:0] cnt_inc;

    always_comb begin
        d = q;
        rise = sig_i & ~q.prev;
        cnt_inc = q.cnt + CNT_W'(1);
        d.prev = sig_i;
        if (rise) begin
            d.cnt = '0;
            d.period = cnt_inc;
            // Two equal periods in a row within range count as a steady input
            d.stable = (cnt_inc == q.period) && (cnt_inc >= MIN_P) && (cnt_inc < CNT_LIMIT);
        end else if (q.cnt >= CNT_LIMIT) begin
            // Input stopped: no longer steady
            d.stable = 1'b0;
        end else begin
            d.cnt = cnt_inc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rise_o = rise;
    assign period_o = q.period;
    assign stable_o = q.stable;

endmodule : bcf_edge_meter
`default_nettype wire

// file: src/bcf_fanout.sv
// Banked clock fan-out with a digital phase-lock loop and a Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module bcf_fanout #(
    parameter int CNT_W = bcf_pkg::BCF_CNT_W_DEF,
    parameter int LOCK_PERIODS = bcf_pkg::BCF_LOCK_PERIODS_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ref_clk_i,
    input wire logic feedback_in_i,
    input wire logic bank_a_enable_i,
    input wire logic bank_b_enable_i,
    input wire logic bank_c_enable_i,
    input wire logic bank_d_enable_i,
    input wire logic loop_bypass_strap_n_i,
    input wire bcf_pkg::bcf_wb_req_s wb_req_i,
    output bcf_pkg::bcf_wb_rsp_s wb_rsp_o,
    output logic [3:0] bank_a_clk_out_o,
    output logic [3:0] bank_b_clk_out_o,
    output logic [3:0] bank_c_clk_out_o,
    output logic [3:0] bank_d_clk_out_o,
    output logic feedback_out_o,
    output logic pll_locked_o
);
    import bcf_pkg::*;

    initial begin
        if (CNT_W < 4 || CNT_W > 32) begin
            $error("bcf_fanout: CNT_W must lie in 4..32");
        end
        if (LOCK_PERIODS < 1 || LOCK_PERIODS >= (1 << (CNT_W - 1))) begin
            $error("bcf_fanout: LOCK_PERIODS out of range");
        end
    end

    localparam logic [CNT_W-1:0] ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] LOCK_N = CNT_W'(LOCK_PERIODS);
    localparam logic [1:0] MISS_N = 2'(BCF_MISS_LIMIT);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        bcf_lock_e st;
        logic [CNT_W-1:0] gen_cnt;
        logic [CNT_W-1:0] ph_cnt;
        logic [CNT_W-1:0] adj;
        logic adj_long;
        logic pend;
        logic applied;
        logic [CNT_W-1:0] lock_cnt;
        logic [CNT_W-1:0] last_delta;
        logic fb_seen;
        logic [1:0] miss;
        logic [BCF_NUM_BANKS-1:0] en;
        logic src;
        logic [BCF_NUM_BANKS*BCF_BANK_WIDTH-1:0] bank_out;
        logic fb_out;
        logic locked;
        logic ack;
        logic [31:0] rdat;
    } bcf_state_s;

    bcf_state_s q, d;

    logic ref_rise;
    logic [CNT_W-1:0] ref_period;
    logic ref_ok;
    logic fb_rise;

    // ------------------------------------------------------------
    // Edge meters for reference and returned feedback
    // ------------------------------------------------------------
    bcf_edge_meter #(
        .CNT_W(CNT_W)
    ) u_ref_meter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sig_i(ref_clk_i),
        .rise_o(ref_rise),
        .period_o(ref_period),
        .stable_o(ref_ok)
    );

    bcf_edge_meter #(
        .CNT_W(CNT_W)
    ) u_fb_meter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sig_i(feedback_in_i),
        .rise_o(fb_rise),
        .period_o(),
        .stable_o()
    );

    // Restart the settling interval: lose lock, drop any pending correction
    function automatic bcf_state_s restart(input bcf_state_s s);
        bcf_state_s r;
        r = s;
        r.st = BCF_LK_ACQUIRE;
        r.lock_cnt = '0;
        r.pend = 1'b0;
        r.applied = 1'b0;
        return r;
    endfunction : restart

    logic bypass;
    logic [BCF_NUM_BANKS-1:0] en_in;
    logic [CNT_W-1:0] half;
    logic [CNT_W-1:0] gen_end;
    logic wrap;
    logic [CNT_W-1:0] delta;
    logic wb_hit;

    always_comb begin
        d = q;
        bypass = ~loop_bypass_strap_n_i;
        en_in = {bank_d_enable_i, bank_c_enable_i, bank_b_enable_i, bank_a_enable_i};
        half = ref_period >> 1;
        wb_hit = wb_req_i.cyc & wb_req_i.stb & ~q.ack;

        // --------------------------------------------------------
        // Output clock generator
        // --------------------------------------------------------
        gen_end = ref_period - ONE;
        if (q.pend && !q.applied) begin
            gen_end = q.adj_long ? (ref_period - ONE + q.adj) : (ref_period - ONE - q.adj);
        end
        wrap = q.gen_cnt >= gen_end;
        if (q.st == BCF_LK_WAIT) begin
            d.gen_cnt = '0;
        end else if (wrap) begin
            d.gen_cnt = '0;
            if (q.pend) begin
                d.applied = 1'b1;
            end
        end else begin
            d.gen_cnt = q.gen_cnt + ONE;
        end

        if (bypass) begin
            d.src = ref_clk_i;
        end else begin
            d.src = (q.st != BCF_LK_WAIT) && (d.gen_cnt < half);
        end

        // --------------------------------------------------------
        // Phase detector: cycles from reference rise to feedback rise
        // --------------------------------------------------------
        d.ph_cnt = ref_rise ? '0 : ((q.ph_cnt == '1) ? q.ph_cnt : q.ph_cnt + ONE);
        // Saturated count must not wrap to zero and fake a coincident edge
        delta = ref_rise ? '0 : ((q.ph_cnt == '1) ? q.ph_cnt : q.ph_cnt + ONE);

        if (fb_rise) begin
            d.fb_seen = 1'b1;
        end

        // --------------------------------------------------------
        // Lock sequencing
        // --------------------------------------------------------
        if (bypass || !ref_ok) begin
            d.st = BCF_LK_WAIT;
            d.lock_cnt = '0;
            d.pend = 1'b0;
            d.applied = 1'b0;
            d.miss = '0;
        end else begin
            if (q.st == BCF_LK_WAIT) begin
                d = restart(d);
            end
            if (ref_rise) begin
                d.fb_seen = fb_rise;
                if (!q.fb_seen && !fb_rise) begin
                    d.miss = (q.miss == MISS_N) ? q.miss : q.miss + 2'd1;
                end else begin
                    d.miss = '0;
                end
                if (q.miss == MISS_N && q.st != BCF_LK_WAIT) begin
                    d = restart(d);
                end
            end
            if (fb_rise && q.st != BCF_LK_WAIT && (!q.pend || q.applied)) begin
                d.last_delta = delta;
                d.pend = 1'b0;
                d.applied = 1'b0;
                if (delta == '0) begin
                    // Edges coincide: count towards lock
                    if (q.lock_cnt + ONE >= LOCK_N) begin
                        d.st = BCF_LK_LOCKED;
                        d.lock_cnt = LOCK_N;
                    end else begin
                        d.lock_cnt = q.lock_cnt + ONE;
                    end
                end else begin
                    d = restart(d);
                    d.pend = 1'b1;
                    d.applied = 1'b0;
                    // Late feedback: shorten next period; early: lengthen it
                    if (delta <= half) begin
                        d.adj = delta;
                        d.adj_long = 1'b0;
                    end else if (delta < ref_period) begin
                        d.adj = ref_period - delta;
                        d.adj_long = 1'b1;
                    end else begin
                        // Feedback beyond a whole period: reference stalled, keep the period
                        d.adj = '0;
                        d.adj_long = 1'b1;
                    end
                end
            end
        end

        // --------------------------------------------------------
        // Register slave
        // --------------------------------------------------------
        d.ack = wb_hit;
        if (wb_hit) begin
            if (wb_req_i.we) begin
                d.rdat = q.rdat;
                if (wb_req_i.adr == BCF_REG_CTRL && wb_req_i.sel[0] && wb_req_i.dat[BCF_CTRL_RELOCK_BIT]) begin
                    if (d.st != BCF_LK_WAIT) begin
                        d = restart(d);
                    end
                end
            end else if (wb_req_i.adr == BCF_REG_CTRL) begin
                d.rdat = '0;
            end else if (wb_req_i.adr == BCF_REG_STATUS) begin
                d.rdat = '0;
                d.rdat[BCF_STAT_LOCKED_BIT] = q.locked;
                d.rdat[BCF_STAT_BYPASS_BIT] = bypass;
                d.rdat[BCF_STAT_STATE_LSB +: 2] = q.st;
                d.rdat[BCF_STAT_EN_LSB +: BCF_NUM_BANKS] = q.en;
                d.rdat[BCF_STAT_REF_OK_BIT] = ref_ok;
            end else if (wb_req_i.adr == BCF_REG_PERIOD) begin
                d.rdat = 32'(ref_period);
            end else if (wb_req_i.adr == BCF_REG_PHASE) begin
                d.rdat = 32'(q.last_delta);
            end else begin
                d.rdat = BCF_RDATA_RESET;
            end
        end

        d.locked = (d.st == BCF_LK_LOCKED) && !bypass;

        // --------------------------------------------------------
        // Bank gating and outputs
        // --------------------------------------------------------
        for (int b = 0; b < BCF_NUM_BANKS; b++) begin
            // Enable follows its pin only while the clock is low
            d.en[b] = d.src ? q.en[b] : en_in[b];
            // Enabled: copy of the clock; disabled: static low
            d.bank_out[b*BCF_BANK_WIDTH +: BCF_BANK_WIDTH] = {BCF_BANK_WIDTH{d.src & d.en[b]}};
        end
        d.fb_out = d.src;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bank_a_clk_out_o = q.bank_out[0 +: BCF_BANK_WIDTH];
    assign bank_b_clk_out_o = q.bank_out[BCF_BANK_WIDTH +: BCF_BANK_WIDTH];
    assign bank_c_clk_out_o = q.bank_out[2*BCF_BANK_WIDTH +: BCF_BANK_WIDTH];
    assign bank_d_clk_out_o = q.bank_out[3*BCF_BANK_WIDTH +: BCF_BANK_WIDTH];
    assign feedback_out_o = q.fb_out;
    assign pll_locked_o = q.locked;
    assign wb_rsp_o = '{ack: q.ack, dat: q.rdat};

endmodule : bcf_fanout
`default_nettype wire

// file: dv/bcf_properties.sv
// Port-level assertions for the banked clock fan-out
`timescale 1ns/1ps
`default_nettype none
module bcf_properties #(
    parameter int LOCK_PERIODS = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ref_clk_i,
    input wire logic feedback_in_i,
    input wire logic bank_a_enable_i,
    input wire logic loop_bypass_strap_n_i,
    input wire bcf_pkg::bcf_wb_req_s wb_req_i,
    input wire bcf_pkg::bcf_wb_rsp_s wb_rsp_o,
    input wire logic [3:0] bank_a_clk_out_o,
    input wire logic [3:0] bank_b_clk_out_o,
    input wire logic feedback_out_o,
    input wire logic pll_locked_o
);
    import bcf_pkg::*;
    logic [7:0] aligned_q;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ----------------------------------------
    // Run of reference rises met by a feedback rise
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || ($rose(ref_clk_i) && !$rose(feedback_in_i))) begin
            aligned_q <= 8'h00;
        end else if ($rose(ref_clk_i) && aligned_q != 8'hFF) begin
            aligned_q <= aligned_q + 8'h01;
        end
    end
    AST_BANK_SAME: assert property (bank_a_clk_out_o inside {4'h0, 4'hF} && bank_b_clk_out_o inside {4'h0, 4'hF})
        else $error("bank copies differ");
    AST_FB_DUTY: assert property (disable iff (rst_i || !pll_locked_o) $rose(feedback_out_o) && pll_locked_o |-> feedback_out_o [*4] ##1 !feedback_out_o [*4])
        else $error("feedback duty wrong");
    AST_FB_TOGGLE: assert property (pll_locked_o && !feedback_out_o |-> ##[1:8] feedback_out_o)
        else $error("feedback stopped");
    AST_BANK_OFF: assert property (!bank_a_enable_i [*8] |-> bank_a_clk_out_o == 4'h0)
        else $error("disabled bank toggles");
    AST_BANK_ON: assert property (bank_a_enable_i [*8] ##0 $rose(feedback_out_o) |-> bank_a_clk_out_o == 4'hF)
        else $error("enabled bank missing pulse");
    AST_NO_RUNT: assert property ($changed(bank_b_clk_out_o) |-> $changed(feedback_out_o))
        else $error("bank edge off the clock edge");
    AST_BYPASS: assert property (!loop_bypass_strap_n_i [*4] |-> feedback_out_o == $past(ref_clk_i, 1) && !pll_locked_o)
        else $error("bypass path wrong");
    AST_LOCK_AFTER: assert property ($rose(pll_locked_o) |-> aligned_q >= LOCK_PERIODS)
        else $error("lock before settling");
    AST_WB_ACK: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
        else $error("bus ack late");
    AST_WB_PULSE: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("bus ack too long");
endmodule : bcf_properties
bind bcf_fanout bcf_properties #(.LOCK_PERIODS(LOCK_PERIODS)) i_props (
    .clk_i(clk_i), .rst_i(rst_i), .ref_clk_i(ref_clk_i), .feedback_in_i(feedback_in_i),
    .bank_a_enable_i(bank_a_enable_i), .loop_bypass_strap_n_i(loop_bypass_strap_n_i),
    .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .bank_a_clk_out_o(bank_a_clk_out_o),
    .bank_b_clk_out_o(bank_b_clk_out_o), .feedback_out_o(feedback_out_o), .pll_locked_o(pll_locked_o)
);
`default_nettype wire

// file: dv/bcf_ref_model.sv
// Reference source and board feedback path facing the fan-out block
`timescale 1ns/1ps
`default_nettype none
module bcf_ref_model (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic loop_cut_i,
    input wire logic fb_out_i,
    output logic ref_o,
    output logic fb_in_o
);
    logic [2:0] cnt_q;
    logic [1:0] dly_q;
    // Fixed period of 8 and short high time; stands low when stopped
    always_ff @(posedge clk_i) begin
        cnt_q <= run_i ? cnt_q + 3'h1 : 3'h0;
        ref_o <= run_i && cnt_q < 3'h2;
        dly_q <= {dly_q[0], fb_out_i};
        fb_in_o <= loop_cut_i ? 1'b0 : dly_q[1];
    end
endmodule : bcf_ref_model
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the banked clock fan-out
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import bcf_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] bank_en = 4'hF;
    logic strap_n = 1'b1;
    logic ref_run = 1'b0;
    logic loop_cut = 1'b0;
    logic ref_clk, fb_in, fb_out, locked;
    logic [3:0] bank_a, bank_b, bank_c, bank_d;
    logic [3:0] r;
    logic [31:0] len;
    bcf_wb_req_s wb_req = '0;
    bcf_wb_rsp_s wb_rsp;
    logic [31:0] exp_q[$];
    int n_errors = 0;
    int n_compared = 0;
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    bcf_ref_model i_src (.clk_i(clk_i), .run_i(ref_run), .loop_cut_i(loop_cut), .fb_out_i(fb_out),
        .ref_o(ref_clk), .fb_in_o(fb_in));
    bcf_fanout #(.CNT_W(16), .LOCK_PERIODS(4)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .ref_clk_i(ref_clk),
        .feedback_in_i(fb_in), .bank_a_enable_i(bank_en[0]), .bank_b_enable_i(bank_en[1]),
        .bank_c_enable_i(bank_en[2]), .bank_d_enable_i(bank_en[3]), .loop_bypass_strap_n_i(strap_n),
        .wb_req_i(wb_req), .wb_rsp_o(wb_rsp), .bank_a_clk_out_o(bank_a), .bank_b_clk_out_o(bank_b),
        .bank_c_clk_out_o(bank_c), .bank_d_clk_out_o(bank_d), .feedback_out_o(fb_out),
        .pll_locked_o(locked));
    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wb_req <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
        @(posedge clk_i);
        while (wb_rsp.ack !== 1'b1) begin
            @(posedge clk_i);
        end
        wb_req <= '0;
        @(posedge clk_i);
    endtask : bus
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, adr, 32'h0);
    endtask : rd
    task automatic wait_sig(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        while (s !== v && n < lim) begin
            n++;
            @(posedge clk_i);
        end
    endtask : wait_sig
    task automatic high_len();
        wait_sig(fb_out, 1'b0, 50);
        wait_sig(fb_out, 1'b1, 50);
        len = 0;
        while (fb_out === 1'b1 && len < 50) begin
            len++;
            @(posedge clk_i);
        end
    endtask : high_len
    function automatic logic [31:0] stat(input logic [3:0] en);
        stat = 32'h0;
        stat[BCF_STAT_LOCKED_BIT] = 1'b1;
        stat[BCF_STAT_STATE_LSB +: 2] = BCF_LK_LOCKED;
        stat[BCF_STAT_EN_LSB +: 4] = en;
        stat[BCF_STAT_REF_OK_BIT] = 1'b1;
    endfunction : stat
    // Read results leave the queue as each read ack appears
    always @(posedge clk_i) begin
        if (wb_rsp.ack === 1'b1 && !wb_req.we && exp_q.size() > 0) begin
            check("rdata", wb_rsp.dat, exp_q.pop_front());
        end
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        n_errors++;
        stop_test();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h38A6));
        r = 4'($urandom());
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        ref_run <= 1'b1;
        @(posedge clk_i);
        bus(1'b1, 8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0);
        rd(BCF_REG_CTRL, 32'h0);
        wait_sig(locked, 1'b1, 2000);
        check("locked", 32'(locked), 32'h1);
        bus(1'b1, BCF_REG_PERIOD, 32'h0000_0055);
        rd(BCF_REG_PERIOD, 32'h8);
        rd(BCF_REG_PHASE, 32'h0);
        high_len();
        check("high_len", len, 32'h4);
        $display("test lock done");
        for (int i = 0; i < 16; i++) begin
            bank_en <= 4'(i) ^ r;
            repeat (16) @(posedge clk_i);
            rd(BCF_REG_STATUS, stat(4'(i) ^ r));
            repeat (8) begin
                @(posedge clk_i);
                check("banks", 32'({bank_d, bank_c, bank_b, bank_a}), 32'({{4{bank_en[3] & fb_out}},
                    {4{bank_en[2] & fb_out}}, {4{bank_en[1] & fb_out}}, {4{bank_en[0] & fb_out}}}));
            end
        end
        $display("test banks done");
        for (int k = 0; k < 3; k++) begin
            if (k == 0) bus(1'b1, BCF_REG_CTRL, 32'h1);
            loop_cut <= (k == 1);
            ref_run <= (k != 2);
            wait_sig(locked, 1'b0, 200);
            check("unlock", 32'(locked), 32'h0);
            loop_cut <= 1'b0;
            ref_run <= 1'b1;
            wait_sig(locked, 1'b1, 2000);
            check("relock", 32'(locked), 32'h1);
        end
        $display("test relock done");
        strap_n <= 1'b0;
        repeat (8) @(posedge clk_i);
        high_len();
        check("bypass_high", len, 32'h2);
        check("bypass_lock", 32'(locked), 32'h0);
        strap_n <= 1'b1;
        wait_sig(locked, 1'b1, 2000);
        check("exit_bypass", 32'(locked), 32'h1);
        $display("test bypass done");
        stop_test();
    end
endmodule : testbench
`default_nettype wire
